// file: logic/exc_pkg.sv
// shared constants and carrier types of the exception and break unit
package exc_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W  = 32;          // register and address width
  localparam int unsigned N_IRQ   = 32;          // interrupt request lines
  localparam int unsigned ADDR_W  = 8;           // apb address width

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h00;  // status_control_reg
  localparam logic [ADDR_W-1:0] OFF_ESTATUS = 8'h04;  // saved status, exception
  localparam logic [ADDR_W-1:0] OFF_BSTATUS = 8'h08;  // saved status, break
  localparam logic [ADDR_W-1:0] OFF_IMASK   = 8'h0c;  // per-line interrupt mask
  localparam logic [ADDR_W-1:0] OFF_IPEND   = 8'h10;  // pending lines, read only
  localparam logic [ADDR_W-1:0] OFF_ERA     = 8'h14;  // exception_return_addr
  localparam logic [ADDR_W-1:0] OFF_BRA     = 8'h18;  // break return address
  localparam logic [ADDR_W-1:0] OFF_MODE    = 8'h1c;  // operating mode, read only

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned       PIE_BIT     = 0;          // enable bit in status words
  localparam int unsigned       MODE_BIT    = 0;          // debug flag in mode word
  localparam logic              STATUS_RST  = 1'b0;       // status clears on reset
  localparam logic [N_IRQ-1:0]  IMASK_RST   = 32'h0000_0000;
  localparam logic [DATA_W-1:0] ADDR_RST    = 32'h0000_0000;
  localparam logic [DATA_W-1:0] INSTR_STEP  = 32'h0000_0004; // one instruction word

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  // kind of instruction standing at the boundary
  typedef enum logic [2:0] {
    op_none,
    op_trap,
    op_unimpl,
    op_eret,
    op_break,
    op_bret
  } op_t;

  // one instruction boundary offered by the pipeline
  typedef struct packed {
    logic              valid;  // boundary present this cycle
    logic [DATA_W-1:0] pc;     // address of the instruction at the boundary
    op_t               op;     // its kind
  } retire_t;

  // change of flow back to the pipeline
  typedef struct packed {
    logic              valid;  // one-cycle pulse
    logic [DATA_W-1:0] target; // next fetch address
  } redirect_t;

  // operating mode
  typedef enum {
    mode_normal,
    mode_debug
  } mode_t;

endpackage : exc_pkg

// file: logic/cpu_sync2.sv
// two-stage synchroniser for asynchronous request pins
`timescale 1ns/1ps

module cpu_sync2
  import exc_pkg::*;
#(
  parameter int unsigned W = 1
)(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ----------------------------------------------------------------
  // two flops; the first one feeds the second only
  // ----------------------------------------------------------------
  logic [W-1:0] meta;  // first stage, may be metastable

  // both stages freeze with the clock enable like all other state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= '0;
      q    <= '0;
    end
    else if (ce)
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : cpu_sync2

// file: logic/cpu_exception_break_unit.sv
// exception, interrupt and break control of the soft core, apb register slave
//
// How it works
// RQ1: interrupt needs enable, request and mask bit
// RQ2: taking an interrupt clears the global enable
// RQ3: pending register shows pending request lines
// RQ4: peripherals hold requests until serviced
// RQ5: writing enable one re-enables interrupts immediately
// RQ6: trap instruction takes a trap exception
// RQ7: unimplemented valid instruction takes its own exception
// RQ8: exception entry saves following instruction address
// RQ9: interrupt return address is interrupted address plus four
// RQ10: exception return restores status and jumps back
// RQ11: break by instruction or debug request
// RQ12: break saves status, clears enable, jumps fixed
// RQ13: break saves following address as return
// RQ14: break return restores status and resumes
// RQ15: break leaves exception save registers untouched
// RQ16: exception saves status, clears enable, jumps fixed
// RQ17: pending bit equals request and mask; writes ignored
// RQ18: reset clears status, starts in normal mode
// RQ19: requests recognised only at instruction boundaries
// RQ20: debug break wins over interrupt
`timescale 1ns/1ps

module cpu_exception_break_unit
  import exc_pkg::*;
#(
  parameter logic [DATA_W-1:0] EXC_HANDLER = 32'h0000_0020, // fixed exception handler
  parameter logic [DATA_W-1:0] BRK_HANDLER = 32'h0000_0100  // fixed break handler
)(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic                   pready,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pslverr,
  input  wire logic [N_IRQ-1:0]  irq_req,
  input  wire logic              dbg_break_req,
  input  wire retire_t           retire,
  output redirect_t              redirect,
  output logic                   debug_active
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic              global_irq_enable;    // status bit
  logic              saved_irq_enable_exc; // status copy on exception
  logic              saved_irq_enable_brk; // status copy on break
  logic [N_IRQ-1:0]  irq_mask;             // per-line enable
  logic [DATA_W-1:0] exception_return_addr;
  logic [DATA_W-1:0] break_return_addr;
  mode_t             mode;                 // normal or debug

  // ----------------------------------------------------------------
  // synchronised pins
  // ----------------------------------------------------------------
  logic [N_IRQ-1:0]  irq_s;    // request lines after two flops
  logic              dbg_s;    // debug break request after two flops

  cpu_sync2 #(.W(N_IRQ)) u_irq_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d       (irq_req),
    .q       (irq_s)
  );

  cpu_sync2 #(.W(1)) u_dbg_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d       (dbg_break_req),
    .q       (dbg_s)
  );

  // ----------------------------------------------------------------
  // interrupt qualification
  // ----------------------------------------------------------------
  logic [N_IRQ-1:0]  pending;  // request and mask per line
  logic              irq_ok;   // some pending line with enable set

  cpu_irq_gate u_gate (
    .irq     (irq_s),
    .mask    (irq_mask),
    .enable  (global_irq_enable),
    .pending (pending),
    .take    (irq_ok)
  );

  // ----------------------------------------------------------------
  // boundary decisions
  // ----------------------------------------------------------------
  logic              boundary;   // instruction boundary, clock enabled
  logic              take_dbg;   // hardware break taken
  logic              take_irq;   // interrupt taken
  op_t               op_go;      // instruction action taken
  logic              exc_entry;  // any exception entry
  logic              brk_entry;  // any break entry
  logic              eret_go;    // exception return
  logic              bret_go;    // break return
  logic [DATA_W-1:0] ret_addr;   // address after the boundary instruction

  // nothing is ever taken between boundaries, so no instruction is split
  assign boundary = ce && retire.valid;                    // RQ19
  // hardware break while already in debug mode would clobber the break copy
  assign take_dbg = boundary && dbg_s && (mode == mode_normal); // RQ11
  // break first, then interrupt, then the instruction's own action
  assign take_irq = boundary && !take_dbg && irq_ok;       // RQ1 RQ20
  assign op_go    = (boundary && !take_dbg && !take_irq) ? retire.op : op_none;
  // the pipeline offers the interrupted instruction, so plus four is its return
  assign ret_addr = retire.pc + INSTR_STEP;                // RQ9

  // entry and return classification
  always_comb
  begin
    exc_entry = take_irq;
    brk_entry = take_dbg;
    eret_go   = 1'b0;
    bret_go   = 1'b0;
    case (op_go)
      op_trap:   exc_entry = 1'b1;                         // RQ6
      op_unimpl: exc_entry = 1'b1;                         // RQ7
      op_eret:   eret_go   = 1'b1;
      op_break:  brk_entry = 1'b1;                         // RQ11
      op_bret:   bret_go   = 1'b1;
      default:   ;                                         // no action
    endcase
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic              wr_en;   // write takes effect this edge
  logic              mapped;  // address hits a register
  logic [DATA_W-1:0] rd_mux;  // value selected for a read

  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wr_en  = ce && psel && penable && pwrite && mapped;

  // address decode
  always_comb
  begin
    case (paddr)
      OFF_STATUS, OFF_ESTATUS, OFF_BSTATUS, OFF_IMASK,
      OFF_IPEND, OFF_ERA, OFF_BRA, OFF_MODE: mapped = 1'b1;
      default:                              mapped = 1'b0;
    endcase
  end

  // unmapped access answers with an error in the access phase
  assign pslverr = psel && penable && !mapped;

  // read selection; unused bits read as zero
  always_comb
  begin
    rd_mux = '0;
    case (paddr)
      OFF_STATUS:  rd_mux[PIE_BIT]  = global_irq_enable;
      OFF_ESTATUS: rd_mux[PIE_BIT]  = saved_irq_enable_exc;
      OFF_BSTATUS: rd_mux[PIE_BIT]  = saved_irq_enable_brk;
      OFF_IMASK:   rd_mux           = irq_mask;
      OFF_IPEND:   rd_mux           = pending;                 // RQ3 RQ17
      OFF_ERA:     rd_mux           = exception_return_addr;
      OFF_BRA:     rd_mux           = break_return_addr;
      OFF_MODE:    rd_mux[MODE_BIT] = (mode == mode_debug);
      default:     rd_mux           = '0;                      // unmapped
    endcase
  end

  // read data captured in the setup cycle, stable through the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (ce && psel && !penable && !pwrite)
      prdata <= rd_mux;
  end

  // ----------------------------------------------------------------
  // status register
  // ----------------------------------------------------------------
  // hardware entry wins over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      global_irq_enable <= STATUS_RST;                          // RQ18
    else if (ce)
    begin
      if (exc_entry || brk_entry)
        global_irq_enable <= 1'b0;                              // RQ2 RQ12 RQ16
      else if (eret_go)
        global_irq_enable <= saved_irq_enable_exc;              // RQ10
      else if (bret_go)
        global_irq_enable <= saved_irq_enable_brk;              // RQ14
      else if (wr_en && paddr == OFF_STATUS)
        global_irq_enable <= pwdata[PIE_BIT];                   // RQ5
    end
  end

  // ----------------------------------------------------------------
  // exception save registers
  // ----------------------------------------------------------------
  // untouched by break entry so a handler can be debugged
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      saved_irq_enable_exc  <= STATUS_RST;
      exception_return_addr <= ADDR_RST;
    end
    else if (ce)
    begin
      if (exc_entry)
      begin
        saved_irq_enable_exc  <= global_irq_enable;             // RQ16
        exception_return_addr <= ret_addr;                      // RQ8 RQ9
      end
      else
      begin
        if (wr_en && paddr == OFF_ESTATUS)
          saved_irq_enable_exc <= pwdata[PIE_BIT];
        if (wr_en && paddr == OFF_ERA)
          exception_return_addr <= pwdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // break save registers and mode
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      saved_irq_enable_brk <= STATUS_RST;
      break_return_addr    <= ADDR_RST;
    end
    else if (ce)
    begin
      if (brk_entry)
      begin
        saved_irq_enable_brk <= global_irq_enable;              // RQ12 RQ15
        break_return_addr    <= ret_addr;                       // RQ13
      end
      else
      begin
        if (wr_en && paddr == OFF_BSTATUS)
          saved_irq_enable_brk <= pwdata[PIE_BIT];
        if (wr_en && paddr == OFF_BRA)
          break_return_addr <= pwdata;
      end
    end
  end

  // mode state machine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode <= mode_normal;                                      // RQ18
    else if (ce)
    begin
      case (mode)
        mode_normal: if (brk_entry) mode <= mode_debug;
        mode_debug:  if (bret_go)   mode <= mode_normal;
        default:     mode <= mode_normal;
      endcase
    end
  end

  assign debug_active = (mode == mode_debug);

  // ----------------------------------------------------------------
  // interrupt mask
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask <= IMASK_RST;
    else if (wr_en && paddr == OFF_IMASK)
      irq_mask <= pwdata;
  end

  // ----------------------------------------------------------------
  // redirect to the pipeline
  // ----------------------------------------------------------------
  // one-cycle pulse the edge after the decision
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      redirect <= '0;
    else if (ce)
    begin
      redirect.valid <= exc_entry || brk_entry || eret_go || bret_go;
      if (brk_entry)
        redirect.target <= BRK_HANDLER;                         // RQ12
      else if (exc_entry)
        redirect.target <= EXC_HANDLER;                         // RQ16
      else if (eret_go)
        redirect.target <= exception_return_addr;               // RQ10
      else if (bret_go)
        redirect.target <= break_return_addr;                   // RQ14
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_exc_jump;
    redirect.valid && redirect.target == EXC_HANDLER && !global_irq_enable;
  endsequence

  sequence s_brk_jump;
    redirect.valid && redirect.target == BRK_HANDLER && !global_irq_enable;
  endsequence

  a_irq_taken_entry: assert property ( // RQ1
    (boundary && !dbg_s && global_irq_enable && |(irq_s & irq_mask))
    |=> s_exc_jump ##0 (exception_return_addr == $past(retire.pc) + INSTR_STEP)
  ) else $error("enabled interrupt not taken");

  a_irq_blocked_off: assert property ( // RQ1
    (boundary && !dbg_s && !global_irq_enable && retire.op == op_none)
    |=> !redirect.valid
  ) else $error("interrupt taken while disabled");

  a_irq_clears_pie: assert property ( // RQ2
    take_irq |=> !global_irq_enable && saved_irq_enable_exc
  ) else $error("interrupt entry did not save and clear enable");

  a_pend_reads_mask: assert property ( // RQ17
    (ce && psel && !penable && !pwrite && paddr == OFF_IPEND)
    |=> prdata == $past(irq_s & irq_mask)
  ) else $error("pending read differs from request and mask");

  a_pie_write_now: assert property ( // RQ5
    (wr_en && paddr == OFF_STATUS && pwdata[PIE_BIT] && !exc_entry && !brk_entry
     && !eret_go && !bret_go)
    |=> global_irq_enable
  ) else $error("enable write did not take effect next cycle");

  a_trap_entry_save: assert property ( // RQ6
    (op_go == op_trap || op_go == op_unimpl)
    |=> s_exc_jump ##0 (saved_irq_enable_exc == $past(global_irq_enable))
        ##0 (exception_return_addr == $past(ret_addr))
  ) else $error("trap or unimplemented entry wrong");

  a_eret_restore: assert property ( // RQ10
    eret_go |=> redirect.valid && redirect.target == $past(exception_return_addr)
                && global_irq_enable == $past(saved_irq_enable_exc)
  ) else $error("exception return wrong");

  a_break_entry: assert property ( // RQ12
    brk_entry |=> s_brk_jump ##0 (break_return_addr == $past(ret_addr))
                  ##0 (saved_irq_enable_brk == $past(global_irq_enable))
                  ##0 debug_active
  ) else $error("break entry wrong");

  a_break_keeps_exc: assert property ( // RQ15
    brk_entry |=> $stable(exception_return_addr) && $stable(saved_irq_enable_exc)
  ) else $error("break disturbed exception save");

  a_bret_restore: assert property ( // RQ14
    bret_go |=> redirect.valid && redirect.target == $past(break_return_addr)
                && global_irq_enable == $past(saved_irq_enable_brk) && !debug_active
  ) else $error("break return wrong");

  a_break_over_irq: assert property ( // RQ20
    (boundary && dbg_s && !debug_active && irq_ok) |=> s_brk_jump
  ) else $error("interrupt won over debug break");

  a_no_boundary_quiet: assert property ( // RQ19
    (ce && !retire.valid) |=> !redirect.valid
  ) else $error("redirect without a boundary");

endmodule : cpu_exception_break_unit

// file: logic/cpu_irq_gate.sv
// interrupt request gating by mask and global enable
`timescale 1ns/1ps

module cpu_irq_gate
  import exc_pkg::*;
(
  input  wire logic [N_IRQ-1:0] irq,
  input  wire logic [N_IRQ-1:0] mask,
  input  wire logic             enable,
  output logic      [N_IRQ-1:0] pending,
  output logic                  take
);

  // ----------------------------------------------------------------
  // per-line gating
  // ----------------------------------------------------------------
  // requests are levels held by the peripheral, so nothing is latched
  for (genvar n = 0; n < N_IRQ; n++)
  begin : g_line
    assign pending[n] = irq[n] && mask[n];  // RQ17 RQ4
  end

  // interrupt only with global enable and some pending line
  assign take = enable && (|pending);       // RQ1

endmodule : cpu_irq_gate

// file: verif/irq_dbg_model.sv
// behavioural peripherals and debug module standing on the request pins
`timescale 1ns/1ps

module irq_dbg_model
  import exc_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [N_IRQ-1:0] fire,        // peripheral raises its line
  input  wire logic [N_IRQ-1:0] service,     // handler has serviced it
  input  wire logic             dbg_fire,    // debugger asks for a break
  input  wire logic             dbg_release, // debugger lets go
  output logic      [N_IRQ-1:0] irq_req,
  output logic                  dbg_break_req
);
  // --------------------------------------------------------------
  // request holders
  // --------------------------------------------------------------
  // the core does not latch, so a line stays up until serviced
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_req <= '0;
    else
      irq_req <= (irq_req | fire) & ~service;
  end

  // hardware break held until released, like a real debug probe
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dbg_break_req <= 1'b0;
    else
      dbg_break_req <= (dbg_break_req | dbg_fire) & ~dbg_release;
  end
endmodule : irq_dbg_model

// file: verif/tb.sv
// self-checking bench of the exception and break unit
`timescale 1ns/1ps

module tb
  import exc_pkg::*;
;
  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  localparam logic [DATA_W-1:0] EXC_H = 32'h0000_0200; // exception handler
  localparam logic [DATA_W-1:0] BRK_H = 32'h0000_0300; // break handler
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              ce = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic              pready;
  logic [DATA_W-1:0] prdata;
  logic              pslverr;
  logic [N_IRQ-1:0]  irq_req, fire = '0, service = '0;
  logic              dbg_break_req, dbg_fire = 1'b0, dbg_release = 1'b0;
  retire_t           retire = '0;
  redirect_t         redirect, r;
  logic              debug_active;
  logic [DATA_W-1:0] d;
  logic              e;
  int                n_errors = 0;
  int                tests_run = 0;

  always #12.5 pclk = ~pclk; // 40 MHz

  cpu_exception_break_unit #(.EXC_HANDLER(EXC_H), .BRK_HANDLER(BRK_H)) dut_u (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .irq_req(irq_req), .dbg_break_req(dbg_break_req),
    .retire(retire), .redirect(redirect), .debug_active(debug_active));

  irq_dbg_model far_u (
    .pclk(pclk), .presetn(presetn), .fire(fire), .service(service),
    .dbg_fire(dbg_fire), .dbg_release(dbg_release), .irq_req(irq_req),
    .dbg_break_req(dbg_break_req));

  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [DATA_W-1:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      n_errors++;
      end_sim();
    end
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input string nm, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
    apb(1'b0, a, '0);
    chk(nm, d, x);
  endtask : rd

  // offer one boundary, then sample the redirect one cycle later
  task automatic step(input logic [DATA_W-1:0] pc, input op_t op);
    @(posedge pclk);
    retire <= '{valid: 1'b1, pc: pc, op: op};
    @(posedge pclk);
    retire <= '0;
    @(negedge pclk);
    r = redirect;
  endtask : step

  task automatic go(input logic [DATA_W-1:0] pc, input op_t op, input logic [DATA_W-1:0] t);
    step(pc, op);
    chk("redirect valid", {31'h0, r.valid}, 32'h1);
    chk("redirect target", r.target, t);
  endtask : go

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_reset;
    rd("status", OFF_STATUS, 32'h0);
    rd("mode", OFF_MODE, 32'h0);
    apb(1'b0, 8'h20, '0);
    chk("unmapped err", {31'h0, e}, 32'h1);
    apb(1'b1, OFF_IPEND, 32'hffff_ffff);
    rd("pending", OFF_IPEND, 32'h0);
  endtask : t_reset

  task automatic t_irq;
    apb(1'b1, OFF_IMASK, 32'h0000_0020);
    fire <= 32'h0000_0020;
    @(posedge pclk);
    fire <= '0;
    repeat (4) @(posedge pclk);
    rd("pending", OFF_IPEND, 32'h0000_0020);
    step(32'h40, op_none);
    chk("masked by enable", {31'h0, r.valid}, 32'h0);
    apb(1'b1, OFF_STATUS, 32'h1);
    go(32'h44, op_none, EXC_H);
    rd("era", OFF_ERA, 32'h48);
    rd("status", OFF_STATUS, 32'h0);
    rd("estatus", OFF_ESTATUS, 32'h1);
    service <= 32'h0000_0020;
    @(posedge pclk);
    service <= '0;
    repeat (4) @(posedge pclk);
    go(32'h60, op_eret, 32'h48);
    rd("status", OFF_STATUS, 32'h1);
  endtask : t_irq

  task automatic t_sw;
    op_t ops[2] = '{op_trap, op_unimpl};
    for (int i = 0; i < 2; i++)
    begin
      go(32'h80 + 16 * i, ops[i], EXC_H);
      rd("era", OFF_ERA, 32'h84 + 16 * i);
      rd("status", OFF_STATUS, 32'h0);
      go(32'h20c, op_eret, 32'h84 + 16 * i);
    end
  endtask : t_sw

  task automatic t_brk;
    apb(1'b1, OFF_IMASK, 32'h0000_0008);
    fire <= 32'h0000_0008;
    dbg_fire <= 1'b1;
    @(posedge pclk);
    fire <= '0;
    dbg_fire <= 1'b0;
    repeat (4) @(negedge pclk);
    chk("no boundary", {31'h0, redirect.valid}, 32'h0);
    go(32'h400, op_none, BRK_H);
    chk("debug", {31'h0, debug_active}, 32'h1);
    rd("bra", OFF_BRA, 32'h404);
    rd("bstatus", OFF_BSTATUS, 32'h1);
    rd("status", OFF_STATUS, 32'h0);
    rd("era kept", OFF_ERA, 32'h94);
    dbg_release <= 1'b1;
    service <= 32'h0000_0008;
    @(posedge pclk);
    dbg_release <= 1'b0;
    service <= '0;
    repeat (4) @(posedge pclk);
    go(32'h310, op_bret, 32'h404);
    rd("status", OFF_STATUS, 32'h1);
    rd("mode", OFF_MODE, 32'h0);
    go(32'h500, op_break, BRK_H);
    rd("bra", OFF_BRA, 32'h504);
    go(32'h310, op_bret, 32'h504);
  endtask : t_brk

  // clock enable low: a trap offered then must leave no trace
  task automatic t_ce;
    @(posedge pclk);
    ce <= 1'b0;
    retire <= '{valid: 1'b1, pc: 32'h600, op: op_trap};
    @(posedge pclk);
    ce <= 1'b1;
    retire <= '0;
    @(negedge pclk);
    chk("frozen boundary", {31'h0, redirect.valid}, 32'h0);
    rd("status kept", OFF_STATUS, 32'h1);
    rd("era kept", OFF_ERA, 32'h94);
  endtask : t_ce

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_irq();
    t_sw();
    t_brk();
    t_ce();
    end_sim();
  end
endmodule : tb
